// file: hdl/tpt_pkg.sv
// Constants shared by the transmit timestamping block and its stamp memory
package tpt_pkg;
    // Field widths
    localparam int TIME_W     = 80;
    localparam int SEC_W      = 48;
    localparam int NS_W       = 32;
    localparam int TAG_W      = 16;
    localparam int LANE_W     = 5;
    localparam int NUM_LANES  = 20;
    localparam int OFFSET_W   = 16;
    localparam int ENTRY_W    = LANE_W + TAG_W + TIME_W;

    // Field positions in the system time word
    localparam int NS_LSB     = 0;
    localparam int SEC_LSB    = 32;
    localparam int TC_SIGN    = 63;
    localparam int TC_NS_LSB  = 16;
    localparam int TC_W       = 64;

    // Per-frame operation codes
    localparam logic [1:0] OP_NONE     = 2'h0;
    localparam logic [1:0] OP_ONE_STEP = 2'h1;
    localparam logic [1:0] OP_TWO_STEP = 2'h2;
    localparam logic [1:0] OP_RESERVED = 2'h3;

    // Checksum flag values
    localparam logic CKSUM_ABSENT  = 1'h0;
    localparam logic CKSUM_PRESENT = 1'h1;

    // Inserted field sizes in bytes
    localparam logic [15:0] STAMP_BYTES_NORMAL = 16'h000A;
    localparam logic [15:0] STAMP_BYTES_TC     = 16'h0008;
    localparam logic [15:0] CKSUM_BYTES        = 16'h0002;

    // One second in nanoseconds
    localparam logic [32:0] NS_PER_SEC = 33'h03B9ACA00;

    // Error flag reset value and the byte written over a zeroed checksum
    localparam logic        ERR_RESET   = 1'h0;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
endpackage

// file: hdl/tpt_stamp_mem.sv
// Small dual-port memory holding queued timestamp entries, registered read
module tpt_stamp_mem #(
    parameter int WIDTH  = 101,
    parameter int ADDR_W = 3
) (
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_srst,
    // Write port
    input  wire logic              i_wr_en,
    input  wire logic [ADDR_W-1:0] i_wr_addr,
    input  wire logic [WIDTH-1:0]  i_wr_data,
    // Read port
    input  wire logic              i_rd_en,
    input  wire logic [ADDR_W-1:0] i_rd_addr,
    output logic      [WIDTH-1:0]  o_rd_data
);
    logic [WIDTH-1:0] mem_q [2**ADDR_W];

    always_ff @(posedge i_ref_clk)
    begin
        if (i_wr_en)
        begin
            mem_q[i_wr_addr] <= i_wr_data;
        end
    end

    // Read register cleared so outputs are defined from reset
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_rd_data <= '0;
        end
        else if (i_rd_en)
        begin
            o_rd_data <= mem_q[i_rd_addr];
        end
    end
endmodule

// file: hdl/tpt_tx_stamp.sv
// Transmit timestamping: one-step insertion, two-step return, tag queue
//
// Contract
// - Normal mode time is 48-bit seconds then 32-bit nanoseconds.
// - Transparent mode: bit 63 sign, 62:16 nanoseconds, 15:0 fractional nanoseconds.
// - Stamp valid is high each cycle a stamp, tag and lane are presented.
// - Five-bit lane number says which of 20 lanes carried start of packet.
// - Tag output returns the tag supplied with the stamped frame.
// - Stamp output holds system time captured at start of packet, same format.
// - Opcode 00 takes no stamp and passes the frame unaltered.
// - Opcode 01 captures a stamp and writes it into the frame.
// - Opcode 10 returns the stamp, frame unchanged; 11 is reserved.
// - Tag ignored for no-operation; returned with stamp for one and two step.
// - Checksum flag set on one-step frames means the UDP checksum is zeroed.
// - Checksum offset counts bytes from first destination address byte at 0.
// - Stamp offset gives byte position of inserted field for one-step frames.
// - Sticky queue write and read errors, cleared only by transmit reset.
// - Lane correction enable adjusts one-step stamps by start-of-packet lane.
module tpt_tx_stamp #(
    parameter int          DATA_BYTES   = 8,
    parameter int          QUEUE_ADDR_W = 3,
    parameter int          BEAT_W       = 12,
    parameter logic [31:0] LANE_STEP_NS = 32'h0000_0001
) (
    // Clock and reset
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_srst,
    // Configuration
    input  wire logic                         i_transparent_mode,
    input  wire logic                         i_lane_skew_correction_enable,
    input  wire logic [tpt_pkg::TIME_W-1:0]   i_tx_system_time_in,
    // Frame stream in
    input  wire logic                         i_tx_valid,
    input  wire logic                         i_tx_sop,
    input  wire logic                         i_tx_eop,
    input  wire logic [8*DATA_BYTES-1:0]      i_tx_data,
    input  wire logic [tpt_pkg::LANE_W-1:0]   i_tx_sop_lane,
    // Per-frame controls
    input  wire logic [1:0]                   i_tx_frame_stamp_opcode,
    input  wire logic [tpt_pkg::TAG_W-1:0]    i_tx_frame_tag,
    input  wire logic                         i_tx_frame_update_checksum,
    input  wire logic [tpt_pkg::OFFSET_W-1:0] i_tx_frame_checksum_offset,
    input  wire logic [tpt_pkg::OFFSET_W-1:0] i_tx_frame_stamp_byte_offset,
    // Frame stream out
    output logic                              o_tx_valid,
    output logic                              o_tx_sop,
    output logic                              o_tx_eop,
    output logic      [8*DATA_BYTES-1:0]      o_tx_data,
    // Stamp return
    output logic                              o_tx_stamp_valid,
    output logic      [tpt_pkg::LANE_W-1:0]   o_tx_stamp_lane_number,
    output logic      [tpt_pkg::TAG_W-1:0]    o_tx_stamp_tag_return,
    output logic      [tpt_pkg::TIME_W-1:0]   o_tx_stamp_value,
    // Status
    output logic                              o_tx_stamp_queue_write_error,
    output logic                              o_tx_stamp_queue_read_error
);
    localparam int DW = 8 * DATA_BYTES;

    typedef struct packed {
        logic                         adj_meta;
        logic                         adj_sync;
        logic [BEAT_W-1:0]            beat;
        logic [1:0]                   op;
        logic                         upd;
        logic [tpt_pkg::OFFSET_W-1:0] ck_off;
        logic [tpt_pkg::OFFSET_W-1:0] ts_off;
        logic [tpt_pkg::TIME_W-1:0]   ts;
        logic                         out_valid;
        logic                         out_sop;
        logic                         out_eop;
        logic                         out_stamp;
        logic [DW-1:0]                out_data;
        logic [QUEUE_ADDR_W:0]        wr_ptr;
        logic [QUEUE_ADDR_W:0]        rd_ptr;
        logic                         stamp_valid;
        logic                         wr_err;
        logic                         rd_err;
    } tpt_state_s;

    tpt_state_s q;
    tpt_state_s d;

    logic                         sop_beat;
    logic [1:0]                   cur_op;
    logic                         cur_upd;
    logic [tpt_pkg::OFFSET_W-1:0] cur_ck_off;
    logic [tpt_pkg::OFFSET_W-1:0] cur_ts_off;
    logic [BEAT_W-1:0]            cur_beat;
    logic [31:0]                  adj_ns;
    logic [32:0]                  ns_sum;
    logic [tpt_pkg::SEC_W-1:0]    sec_new;
    logic [tpt_pkg::NS_W-1:0]     ns_new;
    logic [tpt_pkg::TC_W-1:0]     tc_new;
    logic [tpt_pkg::TIME_W-1:0]   adj_time;
    logic [tpt_pkg::TIME_W-1:0]   cur_ts;
    logic [15:0]                  stamp_len;
    logic [15:0]                  byte_idx;
    logic [15:0]                  rel;
    logic [DW-1:0]                data_mod;
    logic                         q_full;
    logic                         q_empty;
    logic                         wr_req;
    logic                         rd_req;
    logic [tpt_pkg::ENTRY_W-1:0]  rd_entry;

    always_comb
    begin
        d = q;
        // Correction enable is quasi-static from another domain
        d.adj_meta = i_lane_skew_correction_enable;
        d.adj_sync = q.adj_meta;

        sop_beat   = i_tx_valid & i_tx_sop;
        // Controls taken from the first transfer, held for the frame
        cur_op     = sop_beat ? i_tx_frame_stamp_opcode      : q.op;
        cur_upd    = sop_beat ? i_tx_frame_update_checksum   : q.upd;
        cur_ck_off = sop_beat ? i_tx_frame_checksum_offset   : q.ck_off;
        cur_ts_off = sop_beat ? i_tx_frame_stamp_byte_offset : q.ts_off;
        cur_beat   = sop_beat ? '0 : q.beat;

        // Lane correction only for one-step frames
        adj_ns = '0;
        if (q.adj_sync && (i_tx_frame_stamp_opcode == tpt_pkg::OP_ONE_STEP))
        begin
            adj_ns = 32'(LANE_STEP_NS * 32'(i_tx_sop_lane));
        end

        // Time input is used directly: it already lives on this clock
        ns_sum  = {1'b0, i_tx_system_time_in[tpt_pkg::NS_LSB +: tpt_pkg::NS_W]} + {1'b0, adj_ns};
        sec_new = i_tx_system_time_in[tpt_pkg::SEC_LSB +: tpt_pkg::SEC_W];
        ns_new  = ns_sum[31:0];
        if (ns_sum >= tpt_pkg::NS_PER_SEC)
        begin
            ns_new  = 32'(ns_sum - tpt_pkg::NS_PER_SEC);
            sec_new = sec_new + 48'h1;
        end
        // Correction lands in the nanosecond field above the fraction
        tc_new = i_tx_system_time_in[tpt_pkg::TC_W-1:0]
                 + {16'h0000, adj_ns, 16'h0000};
        tc_new[tpt_pkg::TC_SIGN] = i_tx_system_time_in[tpt_pkg::TC_SIGN];
        adj_time = i_transparent_mode
                 ? {i_tx_system_time_in[tpt_pkg::TIME_W-1:tpt_pkg::TC_W], tc_new}
                 : {sec_new, ns_new};
        cur_ts    = sop_beat ? adj_time : q.ts;
        stamp_len = i_transparent_mode ? tpt_pkg::STAMP_BYTES_TC : tpt_pkg::STAMP_BYTES_NORMAL;

        // Byte 0 of a beat sits in the top lane
        data_mod = i_tx_data;
        byte_idx = '0;
        rel      = '0;
        for (int k = 0; k < DATA_BYTES; k++)
        begin
            byte_idx = 16'(cur_beat) * 16'(DATA_BYTES) + 16'(k);
            rel      = byte_idx - cur_ts_off;
            if (cur_op == tpt_pkg::OP_ONE_STEP)
            begin
                if ((byte_idx >= cur_ts_off) && (rel < stamp_len))
                begin
                    data_mod[8*(DATA_BYTES-1-k) +: 8] = i_transparent_mode
                        ? cur_ts[tpt_pkg::TC_W-1-8*rel[3:0] -: 8]
                        : cur_ts[tpt_pkg::TIME_W-1-8*rel[3:0] -: 8];
                end
                // Zeroed checksum is the UDP "not computed" value; even offset assumed
                if ((cur_upd == tpt_pkg::CKSUM_PRESENT) && (byte_idx >= cur_ck_off)
                    && (byte_idx - cur_ck_off < tpt_pkg::CKSUM_BYTES))
                begin
                    data_mod[8*(DATA_BYTES-1-k) +: 8] = tpt_pkg::BYTE_ZERO;
                end
            end
        end

        // Output stage; no-operation and two-step frames pass untouched
        d.out_valid = i_tx_valid;
        d.out_sop   = sop_beat;
        d.out_eop   = i_tx_valid & i_tx_eop;
        d.out_data  = data_mod;
        d.out_stamp = sop_beat && ((cur_op == tpt_pkg::OP_ONE_STEP)
                                || (cur_op == tpt_pkg::OP_TWO_STEP));

        if (i_tx_valid)
        begin
            d.beat = i_tx_eop ? '0 : cur_beat + BEAT_W'(1);
        end
        if (sop_beat)
        begin
            d.op     = cur_op;
            d.upd    = cur_upd;
            d.ck_off = cur_ck_off;
            d.ts_off = cur_ts_off;
            d.ts     = adj_time;
        end

        // Queue of pending stamps; reserved and no-op codes queue nothing
        q_empty = (q.wr_ptr == q.rd_ptr);
        q_full  = (q.wr_ptr == {~q.rd_ptr[QUEUE_ADDR_W], q.rd_ptr[QUEUE_ADDR_W-1:0]});
        wr_req  = d.out_stamp;
        rd_req  = q.out_valid & q.out_sop & q.out_stamp;
        if (wr_req)
        begin
            if (q_full)
            begin
                d.wr_err = 1'b1;
            end
            else
            begin
                d.wr_ptr = q.wr_ptr + (QUEUE_ADDR_W+1)'(1);
            end
        end
        d.stamp_valid = 1'b0;
        if (rd_req)
        begin
            if (q_empty)
            begin
                d.rd_err = 1'b1;
            end
            else
            begin
                d.rd_ptr      = q.rd_ptr + (QUEUE_ADDR_W+1)'(1);
                d.stamp_valid = 1'b1;
            end
        end
    end

    // Errors clear only on transmit path reset
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            q        <= '0;
            q.wr_err <= tpt_pkg::ERR_RESET;
            q.rd_err <= tpt_pkg::ERR_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    tpt_stamp_mem #(
        .WIDTH  (tpt_pkg::ENTRY_W),
        .ADDR_W (QUEUE_ADDR_W)
    ) u_stamp_mem (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_wr_en   (wr_req & ~q_full),
        .i_wr_addr (q.wr_ptr[QUEUE_ADDR_W-1:0]),
        .i_wr_data ({i_tx_sop_lane, i_tx_frame_tag, adj_time}),
        .i_rd_en   (rd_req & ~q_empty),
        .i_rd_addr (q.rd_ptr[QUEUE_ADDR_W-1:0]),
        .o_rd_data (rd_entry)
    );

    assign o_tx_valid = q.out_valid;
    assign o_tx_sop   = q.out_sop;
    assign o_tx_eop   = q.out_eop;
    assign o_tx_data  = q.out_data;

    assign o_tx_stamp_valid       = q.stamp_valid;
    assign o_tx_stamp_lane_number = rd_entry[tpt_pkg::ENTRY_W-1 -: tpt_pkg::LANE_W];
    assign o_tx_stamp_tag_return  = rd_entry[tpt_pkg::TIME_W +: tpt_pkg::TAG_W];
    assign o_tx_stamp_value       = rd_entry[tpt_pkg::TIME_W-1:0];

    assign o_tx_stamp_queue_write_error = q.wr_err;
    assign o_tx_stamp_queue_read_error  = q.rd_err;
endmodule

// file: testbench/tpt_tx_stamp_chk.sv
// Port-level checker for the transmit timestamping block
module tpt_tx_stamp_chk #(
    parameter int DATA_BYTES = 8
) (
    // Inputs of the block
    input wire logic                    i_ref_clk,
    input wire logic                    i_srst,
    input wire logic [79:0]             i_tx_system_time_in,
    input wire logic                    i_tx_valid,
    input wire logic                    i_tx_sop,
    input wire logic [8*DATA_BYTES-1:0] i_tx_data,
    input wire logic [4:0]              i_tx_sop_lane,
    input wire logic [1:0]              i_tx_frame_stamp_opcode,
    input wire logic [15:0]             i_tx_frame_tag,
    // Outputs of the block
    input wire logic                    o_tx_valid,
    input wire logic [8*DATA_BYTES-1:0] o_tx_data,
    input wire logic                    o_tx_stamp_valid,
    input wire logic [4:0]              o_tx_stamp_lane_number,
    input wire logic [15:0]             o_tx_stamp_tag_return,
    input wire logic [79:0]             o_tx_stamp_value,
    input wire logic                    o_tx_stamp_queue_write_error,
    input wire logic                    o_tx_stamp_queue_read_error
);
    logic [1:0] op_q;
    logic       stamp_sop;
    logic       keep_beat;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    assign stamp_sop = i_tx_valid && i_tx_sop && (i_tx_frame_stamp_opcode inside {2'h1, 2'h2});
    // Beats of frames that are not one-step must pass untouched
    assign keep_beat = i_tx_valid && ((i_tx_sop ? i_tx_frame_stamp_opcode : op_q) != 2'h1);

    always_ff @(posedge i_ref_clk)
        if (i_srst)
            op_q <= 2'h0;
        else if (i_tx_valid && i_tx_sop)
            op_q <= i_tx_frame_stamp_opcode;

    property p_stamp_lat;
        stamp_sop |-> ##2 o_tx_stamp_valid;
    endproperty
    a_stamp_lat: assert property (p_stamp_lat) else $error("stamp valid missing");
    property p_no_stray;
        o_tx_stamp_valid |-> $past(stamp_sop, 2);
    endproperty
    a_no_stray: assert property (p_no_stray) else $error("stamp without cause");
    property p_tag;
        stamp_sop |-> ##2 o_tx_stamp_tag_return == $past(i_tx_frame_tag, 2);
    endproperty
    a_tag: assert property (p_tag) else $error("tag return wrong");
    property p_lane;
        stamp_sop |-> ##2 o_tx_stamp_lane_number == $past(i_tx_sop_lane, 2);
    endproperty
    a_lane: assert property (p_lane) else $error("lane number wrong");
    property p_time;
        stamp_sop && i_tx_frame_stamp_opcode == 2'h2
            |-> ##2 o_tx_stamp_value == $past(i_tx_system_time_in, 2);
    endproperty
    a_time: assert property (p_time) else $error("two-step value wrong");
    property p_keep;
        keep_beat |=> o_tx_valid && o_tx_data == $past(i_tx_data);
    endproperty
    a_keep: assert property (p_keep) else $error("frame altered");
    property p_idle;
        !i_tx_valid |=> !o_tx_valid;
    endproperty
    a_idle: assert property (p_idle) else $error("stray beat");
    property p_wr_err;
        o_tx_stamp_queue_write_error |=> o_tx_stamp_queue_write_error;
    endproperty
    a_wr_err: assert property (p_wr_err) else $error("write error cleared");
    property p_rd_err;
        o_tx_stamp_queue_read_error |=> o_tx_stamp_queue_read_error;
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("read error cleared");

    c_two: cover property (stamp_sop && i_tx_frame_stamp_opcode == 2'h2);
    c_one: cover property (stamp_sop && i_tx_frame_stamp_opcode == 2'h1);
    c_none: cover property (i_tx_valid && i_tx_sop && !stamp_sop);
endmodule

bind tpt_tx_stamp tpt_tx_stamp_chk #(.DATA_BYTES(DATA_BYTES)) chk_u (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_tx_system_time_in(i_tx_system_time_in),
    .i_tx_valid(i_tx_valid), .i_tx_sop(i_tx_sop), .i_tx_data(i_tx_data),
    .i_tx_sop_lane(i_tx_sop_lane), .i_tx_frame_stamp_opcode(i_tx_frame_stamp_opcode),
    .i_tx_frame_tag(i_tx_frame_tag), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
    .o_tx_stamp_valid(o_tx_stamp_valid), .o_tx_stamp_lane_number(o_tx_stamp_lane_number),
    .o_tx_stamp_tag_return(o_tx_stamp_tag_return), .o_tx_stamp_value(o_tx_stamp_value),
    .o_tx_stamp_queue_write_error(o_tx_stamp_queue_write_error),
    .o_tx_stamp_queue_read_error(o_tx_stamp_queue_read_error));

// file: testbench/tpt_client_model.sv
// Client transmit model: free-running system time and frame beats
module tpt_client_model (
    // Clock
    input  wire logic        i_ref_clk,
    // Stream towards the block
    output logic             o_valid,
    output logic             o_sop,
    output logic             o_eop,
    output logic [63:0]      o_data,
    output logic [79:0]      o_time
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        o_valid = 1'b0;
        o_sop   = 1'b0;
        o_eop   = 1'b0;
        o_data  = 64'h0;
        o_time  = {48'h0000_0000_0001, 32'h0000_0000};
    end

    // Time moves on the same clock as the block, never resynchronised
    always @(negedge i_ref_clk)
        o_time[31:0] <= o_time[31:0] + 32'h0000_0001;

    // Byte i of the frame carries value i; t is the time seen with the first beat
    task automatic send(input int nb, output logic [79:0] t);
        for (int b = 0; b < nb; b++)
        begin
            @(negedge i_ref_clk);
            o_valid = 1'b1;
            o_sop   = (b == 0);
            o_eop   = (b == nb - 1);
            for (int k = 0; k < 8; k++)
                o_data[63-8*k -: 8] = 8'(8 * b + k);
            #1;
            if (b == 0)
                t = o_time;
        end
        @(negedge i_ref_clk);
        o_valid = 1'b0;
        o_sop   = 1'b0;
        o_eop   = 1'b0;
        o_data  = ~o_data;
    endtask
endmodule

// file: testbench/test_tx_ptp_timestamping.sv
// Self-checking bench for the transmit timestamping block
module test_tx_ptp_timestamping;
    timeunit 1ns;
    timeprecision 1ns;

    logic        i_ref_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_transparent_mode = 1'b0;
    logic        i_lane_skew_correction_enable = 1'b0;
    logic [79:0] i_tx_system_time_in;
    logic        i_tx_valid;
    logic        i_tx_sop;
    logic        i_tx_eop;
    logic [63:0] i_tx_data;
    logic [4:0]  i_tx_sop_lane = 5'h00;
    logic [1:0]  i_tx_frame_stamp_opcode = 2'h0;
    logic [15:0] i_tx_frame_tag = 16'h0000;
    logic        i_tx_frame_update_checksum = 1'b0;
    logic [15:0] i_tx_frame_checksum_offset = 16'h0000;
    logic [15:0] i_tx_frame_stamp_byte_offset = 16'h0000;
    logic        o_tx_valid;
    logic        o_tx_sop;
    logic        o_tx_eop;
    logic [63:0] o_tx_data;
    logic        o_tx_stamp_valid;
    logic [4:0]  o_tx_stamp_lane_number;
    logic [15:0] o_tx_stamp_tag_return;
    logic [79:0] o_tx_stamp_value;
    logic        o_tx_stamp_queue_write_error;
    logic        o_tx_stamp_queue_read_error;
    int          mismatches = 0;
    int          checks = 0;
    int          stamps = 0;
    int          cycles = 0;
    logic [65:0] out_q [$];

    tpt_client_model client_u (.i_ref_clk(i_ref_clk), .o_valid(i_tx_valid), .o_sop(i_tx_sop),
        .o_eop(i_tx_eop), .o_data(i_tx_data), .o_time(i_tx_system_time_in));

    tpt_tx_stamp dut_u (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
        .i_transparent_mode(i_transparent_mode),
        .i_lane_skew_correction_enable(i_lane_skew_correction_enable),
        .i_tx_system_time_in(i_tx_system_time_in), .i_tx_valid(i_tx_valid),
        .i_tx_sop(i_tx_sop), .i_tx_eop(i_tx_eop), .i_tx_data(i_tx_data),
        .i_tx_sop_lane(i_tx_sop_lane), .i_tx_frame_stamp_opcode(i_tx_frame_stamp_opcode),
        .i_tx_frame_tag(i_tx_frame_tag), .i_tx_frame_update_checksum(i_tx_frame_update_checksum),
        .i_tx_frame_checksum_offset(i_tx_frame_checksum_offset),
        .i_tx_frame_stamp_byte_offset(i_tx_frame_stamp_byte_offset),
        .o_tx_valid(o_tx_valid), .o_tx_sop(o_tx_sop), .o_tx_eop(o_tx_eop), .o_tx_data(o_tx_data),
        .o_tx_stamp_valid(o_tx_stamp_valid), .o_tx_stamp_lane_number(o_tx_stamp_lane_number),
        .o_tx_stamp_tag_return(o_tx_stamp_tag_return), .o_tx_stamp_value(o_tx_stamp_value),
        .o_tx_stamp_queue_write_error(o_tx_stamp_queue_write_error),
        .o_tx_stamp_queue_read_error(o_tx_stamp_queue_read_error));

    initial
        forever #4 i_ref_clk = ~i_ref_clk;

    // Collect outputs once settled, away from the launching edge
    always @(negedge i_ref_clk)
    begin
        cycles++;
        if (o_tx_valid === 1'b1)
            out_q.push_back({o_tx_sop, o_tx_eop, o_tx_data});
        if (o_tx_stamp_valid === 1'b1)
            stamps++;
        if (cycles == 3000)
        begin
            mismatches++;
            final_report();
        end
    end

    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Sends one frame and judges the stream copy and the returned stamp
    task automatic run_frame(input logic [1:0] op, input logic [15:0] tag, input logic [4:0] ln,
        input logic cks, input int cko, input int tso, input int nb, input logic corr,
        input logic tm);
        logic [79:0] t;
        logic [79:0] ev;
        logic [63:0] eb;
        logic [7:0]  ex [0:31];
        @(negedge i_ref_clk);
        i_lane_skew_correction_enable = corr;
        i_transparent_mode = tm;
        i_tx_frame_stamp_opcode = op;
        i_tx_frame_tag = tag;
        i_tx_sop_lane = ln;
        i_tx_frame_update_checksum = cks;
        i_tx_frame_checksum_offset = 16'(cko);
        i_tx_frame_stamp_byte_offset = 16'(tso);
        // Correction enable passes a two-flop synchroniser first
        repeat (3) @(negedge i_ref_clk);
        out_q.delete();
        stamps = 0;
        client_u.send(nb, t);
        repeat (4) @(negedge i_ref_clk);
        ev = t;
        if (corr && op == 2'h1)
            ev = tm ? t + (80'(ln) << 16) : {t[79:32], t[31:0] + 32'(ln)};
        for (int i = 0; i < 32; i++)
            ex[i] = 8'(i);
        if (op == 2'h1)
        begin
            for (int j = 0; j < (tm ? 8 : 10); j++)
                ex[tso+j] = tm ? ev[63-8*j -: 8] : ev[79-8*j -: 8];
            if (cks)
            begin
                ex[cko] = 8'h00;
                ex[cko+1] = 8'h00;
            end
        end
        check(80'(stamps), 80'(op == 2'h1 || op == 2'h2));
        check(80'(out_q.size()), 80'(nb));
        for (int b = 0; b < nb && b < out_q.size(); b++)
        begin
            for (int k = 0; k < 8; k++)
                eb[63-8*k -: 8] = ex[8*b+k];
            check(80'(out_q[b]), 80'({b == 0, b == nb - 1, eb}));
        end
        if (op == 2'h1 || op == 2'h2)
        begin
            check(80'(o_tx_stamp_tag_return), 80'(tag));
            check(80'(o_tx_stamp_lane_number), 80'(ln));
            check(o_tx_stamp_value, ev);
        end
        check(80'({o_tx_stamp_queue_write_error, o_tx_stamp_queue_read_error}), 80'h0);
    endtask

    task automatic t_reset();
        check(o_tx_stamp_value, 80'h0);
        check(80'({o_tx_stamp_queue_write_error, o_tx_stamp_queue_read_error}), 80'h0);
    endtask

    task automatic t_two_step();
        // Checksum and correction settings must not touch a two-step frame
        run_frame(2'h2, 16'hA5C3, 5'h07, 1'b1, 4, 2, 3, 1'b1, 1'b0);
    endtask

    task automatic t_no_stamp();
        run_frame(2'h0, 16'h1234, 5'h02, 1'b1, 2, 2, 1, 1'b0, 1'b0);
        run_frame(2'h3, 16'h4321, 5'h04, 1'b1, 2, 2, 2, 1'b0, 1'b0);
    endtask

    task automatic t_one_step();
        run_frame(2'h1, 16'h0F0E, 5'h00, 1'b1, 16, 4, 3, 1'b0, 1'b0);
        run_frame(2'h1, 16'hBEEF, 5'h13, 1'b0, 2, 6, 3, 1'b1, 1'b0);
    endtask

    task automatic t_transparent();
        run_frame(2'h1, 16'h7777, 5'h03, 1'b1, 12, 2, 2, 1'b1, 1'b1);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(negedge i_ref_clk);
        i_srst = 1'b0;
        t_reset();
        t_two_step();
        t_no_stamp();
        t_one_step();
        t_transparent();
        final_report();
    end
endmodule
